//--- logic/rcs_pkg.sv
// selector package: slot map, reset values, field codes
// assumes inputs 1..6, 8, 9 sit in slots 0..7
package rcs_pkg;

    localparam int RCS_SLOTS = 8;
    localparam int RCS_PRIO_W = 4;
    localparam int RCS_SLOT_W = 3;
    localparam int RCS_CODE_W = 4;
    localparam int RCS_TOL_W = 10;

    // input number carried by each slot, one nibble per slot, slot 0 lowest
    localparam logic [31:0] RCS_SLOT_CODES = 32'h9865_4321;

    // reset priority tables, one nibble per slot
    localparam logic [31:0] RCS_MAIN_PRIO_RST = 32'h5400_3210;
    localparam logic [31:0] RCS_AUX_PRIO_RST = 32'h0500_3210;

    localparam logic [3:0] RCS_PRIO_OFF = 4'h0;
    localparam logic [3:0] RCS_CODE_NONE = 4'h0;

    // force field codes
    localparam logic [3:0] RCS_FORCE_AUTO_LO = 4'h0;
    localparam logic [3:0] RCS_FORCE_AUTO_HI = 4'hF;

    // slots used by the pin-driven clock switch
    localparam logic [2:0] RCS_SLOT_IN3 = 3'h2;
    localparam logic [2:0] RCS_SLOT_IN4 = 3'h3;
    localparam logic [2:0] RCS_SLOT_IN5 = 3'h4;
    localparam logic [2:0] RCS_SLOT_IN6 = 3'h5;

    // tolerance limits in tenths of a ppm
    localparam logic [9:0] RCS_TOL_NORMAL = 10'h05C;
    localparam logic [9:0] RCS_TOL_PIN = 10'h320;

    typedef enum logic [1:0] {
        RCS_FORCE_AUTO,
        RCS_FORCE_SLOT,
        RCS_FORCE_NONE
    } rcs_force_type;

    function automatic logic [3:0] rcs_slot_code(input logic [2:0] slot);
        rcs_slot_code = RCS_SLOT_CODES[slot * 4 +: 4];
    endfunction : rcs_slot_code

    function automatic rcs_force_type rcs_force_kind(input logic [3:0] code);
        rcs_force_type kind;
        kind = RCS_FORCE_NONE;
        if (code == RCS_FORCE_AUTO_LO || code == RCS_FORCE_AUTO_HI)
        begin
            kind = RCS_FORCE_AUTO;
        end
        for (int s = 0; s < RCS_SLOTS; s++)
        begin
            if (RCS_SLOT_CODES[s * 4 +: 4] == code)
            begin
                kind = RCS_FORCE_SLOT;
            end
        end
        rcs_force_kind = kind;
    endfunction : rcs_force_kind

    function automatic logic [2:0] rcs_force_slot(input logic [3:0] code);
        logic [2:0] slot;
        slot = 3'h0;
        for (int s = 0; s < RCS_SLOTS; s++)
        begin
            if (RCS_SLOT_CODES[s * 4 +: 4] == code)
            begin
                slot = s[2:0];
            end
        end
        rcs_force_slot = slot;
    endfunction : rcs_force_slot

endpackage : rcs_pkg

//--- logic/rcs_rank.sv
// ranking of eligible inputs for one loop: best three by priority, then circular order
// assumes the caller registers the results; purely combinational
`timescale 1ns/10ps
module rcs_rank
    import rcs_pkg::*;
(
    // candidates
    input wire logic [7:0] elig_in,
    input wire logic [31:0] prio_in,
    input wire logic [2:0] start_in,
    // forcing
    input wire logic force_on_in,
    input wire logic [2:0] force_slot_in,
    input wire logic force_ok_in,
    // ranked result
    output logic [2:0] first_out,
    output logic first_ok_out,
    output logic first_forced_out,
    output logic [2:0] second_out,
    output logic second_ok_out,
    output logic [2:0] third_out,
    output logic third_ok_out
);

    logic [6:0] key [8];

    // low key wins: priority first, ties by distance from the circle start
    genvar g;
    generate
        for (g = 0; g < RCS_SLOTS; g++)
        begin : g_key
            assign key[g] = {prio_in[g * 4 +: 4], 3'(3'(g) - start_in)};
        end
    endgenerate

    function automatic logic [3:0] pick(input logic [7:0] mask);
        logic [6:0] best;
        logic [3:0] res;
        best = 7'h7F;
        res = 4'h0;
        for (int s = 0; s < RCS_SLOTS; s++)
        begin
            if (mask[s] && (!res[3] || key[s] < best))
            begin
                best = key[s];
                res = {1'b1, s[2:0]};
            end
        end
        pick = res;
    endfunction : pick

    logic [3:0] n1;
    logic [3:0] n2;
    logic [3:0] n3;

    always_comb
    begin
        n1 = pick(elig_in);
        n2 = pick(elig_in & ~(8'(n1[3]) << n1[2:0]));
        n3 = pick(elig_in & ~(8'(n1[3]) << n1[2:0]) & ~(8'(n2[3]) << n2[2:0]));
        if (force_on_in && force_ok_in)
        begin
            // forced input on top, normal best and second pushed down
            first_out = force_slot_in;
            first_ok_out = 1'b1;
            first_forced_out = 1'b1;
            second_out = n1[2:0];
            second_ok_out = n1[3];
            third_out = n2[2:0];
            third_ok_out = n2[3];
        end
        else
        begin
            first_out = n1[2:0];
            first_ok_out = n1[3];
            first_forced_out = 1'b0;
            second_out = n2[2:0];
            second_ok_out = n2[3];
            third_out = n3[2:0];
            third_ok_out = n3[3];
        end
    end

endmodule : rcs_rank

//--- logic/rcs_selector.sv
// reference selector for the main and auxiliary loops: priorities, ranking, tracking
// assumes validity faults and missing-cycle pulses arrive synchronous to clk_in
`timescale 1ns/10ps
module rcs_selector
    import rcs_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // priority table access
    input wire logic priority_view_select_in,
    input wire logic prio_wr_in,
    input wire logic [2:0] prio_wr_slot_in,
    input wire logic [3:0] prio_wr_data_in,
    // selection controls
    input wire logic return_to_best_enable_in,
    input wire logic [3:0] main_loop_force_input_in,
    input wire logic [3:0] aux_loop_force_input_in,
    input wire logic aux_measures_main_in,
    input wire logic fast_switch_enable_in,
    // monitor results per slot; missing cycles for the main tracked input
    input wire logic [7:0] freq_fault_in,
    input wire logic [7:0] activity_fault_in,
    input wire logic [7:0] phase_fault_in,
    input wire logic missing_cycles_in,
    // pin switch and tolerance
    input wire logic switch_select_pin_in,
    input wire logic pin_switch_wr_in,
    input wire logic pin_switch_data_in,
    input wire logic tol_wr_in,
    input wire logic [9:0] tol_data_in,
    // status clear and enable
    input wire logic [7:0] latched_clear_in,
    input wire logic [7:0] irq_enable_in,
    input wire logic tracked_fault_clear_in,
    // outputs
    output logic [31:0] input_priority_regs_out,
    output logic [7:0] ranked_table_view_a_out,
    output logic [7:0] ranked_table_view_b_out,
    output logic [3:0] main_tracked_out,
    output logic [3:0] aux_tracked_out,
    output logic [7:0] validity_status_a_out,
    output logic [7:0] latched_status_a_out,
    output logic interrupt_request_pin_out,
    output logic tracked_input_fault_out,
    output logic pin_switch_enable_out,
    output logic [9:0] frequency_tolerance_limit_out,
    output logic [7:0] bucket_force_out,
    output logic enter_prelocked2_out
);

    logic [31:0] main_prio_r;
    logic [31:0] aux_prio_r;
    logic [2:0] main_trk_r;
    logic main_trk_ok_r;
    logic [2:0] main_trk_nxt;
    logic main_trk_ok_nxt;
    logic [2:0] aux_trk_r;
    logic aux_trk_ok_r;
    logic [2:0] aux_trk_nxt;
    logic aux_trk_ok_nxt;
    logic [7:0] fast_fail_r;
    logic [7:0] valid_prev_r;
    logic [7:0] valid_now;
    logic [7:0] trk_onehot;
    logic [7:0] main_elig;
    logic [7:0] aux_elig;
    rcs_force_type main_fkind;
    rcs_force_type aux_fkind;
    logic [2:0] main_fslot;
    logic [2:0] aux_fslot;
    logic fast_event;

    logic [2:0] m_first;
    logic m_first_ok;
    logic m_first_forced;
    logic [2:0] m_second;
    logic m_second_ok;
    logic [2:0] m_third;
    logic m_third_ok;
    logic [2:0] a_first;
    logic a_first_ok;
    logic a_first_forced;
    logic [2:0] a_second;
    logic a_second_ok;
    logic [2:0] a_third;
    logic a_third_ok;

    function automatic logic [3:0] code_of(input logic ok, input logic [2:0] slot);
        code_of = ok ? rcs_slot_code(slot) : RCS_CODE_NONE;
    endfunction : code_of

    function automatic logic [7:0] nonzero(input logic [31:0] table_v);
        logic [7:0] m;
        m = 8'h00;
        for (int s = 0; s < RCS_SLOTS; s++)
        begin
            m[s] = table_v[s * 4 +: 4] != RCS_PRIO_OFF;
        end
        nonzero = m;
    endfunction : nonzero

    // next tracked input of one loop from the current one and the top entry
    function automatic logic [3:0] choose(
        input logic cur_ok,
        input logic [2:0] cur,
        input logic [7:0] usable,
        input logic [31:0] table_v,
        input logic first_ok,
        input logic [2:0] first,
        input logic first_forced,
        input logic return_to_best_enable,
        input rcs_force_type fkind
    );
        logic [3:0] res;
        res = {cur_ok, cur};
        if (fkind == RCS_FORCE_NONE)
        begin
            res = 4'h0;
        end
        else if (!cur_ok || !usable[cur])
        begin
            res = {first_ok, first};
        end
        else if (return_to_best_enable && first_ok && first != cur)
        begin
            // equal priority displaces the tracked input only when the top entry is forced
            if (first_forced || table_v[first * 4 +: 4] < table_v[cur * 4 +: 4])
            begin
                res = {1'b1, first};
            end
        end
        choose = res;
    endfunction : choose

    // validity: phase-lock fault counts only against a tracked input
    always_comb
    begin
        trk_onehot = (8'(main_trk_ok_r) << main_trk_r) | (8'(aux_trk_ok_r) << aux_trk_r);
        valid_now = ~freq_fault_in & ~activity_fault_in & ~(phase_fault_in & trk_onehot)
            & ~fast_fail_r;
        main_elig = valid_now & nonzero(main_prio_r);
        aux_elig = valid_now & nonzero(aux_prio_r);
        main_fkind = rcs_force_kind(main_loop_force_input_in);
        aux_fkind = rcs_force_kind(aux_loop_force_input_in);
        main_fslot = rcs_force_slot(main_loop_force_input_in);
        aux_fslot = rcs_force_slot(aux_loop_force_input_in);
        fast_event = missing_cycles_in && fast_switch_enable_in && main_trk_ok_r;
    end

    rcs_rank u_main_rank (
        .elig_in(main_elig),
        .prio_in(main_prio_r),
        .start_in(3'(main_trk_r + 3'h1)),
        .force_on_in(main_fkind == RCS_FORCE_SLOT),
        .force_slot_in(main_fslot),
        .force_ok_in(valid_now[main_fslot]),
        .first_out(m_first),
        .first_ok_out(m_first_ok),
        .first_forced_out(m_first_forced),
        .second_out(m_second),
        .second_ok_out(m_second_ok),
        .third_out(m_third),
        .third_ok_out(m_third_ok)
    );

    rcs_rank u_aux_rank (
        .elig_in(aux_elig),
        .prio_in(aux_prio_r),
        .start_in(3'(aux_trk_r + 3'h1)),
        .force_on_in(aux_fkind == RCS_FORCE_SLOT),
        .force_slot_in(aux_fslot),
        .force_ok_in(valid_now[aux_fslot]),
        .first_out(a_first),
        .first_ok_out(a_first_ok),
        .first_forced_out(a_first_forced),
        .second_out(a_second),
        .second_ok_out(a_second_ok),
        .third_out(a_third),
        .third_ok_out(a_third_ok)
    );

    // tracked input choice for both loops, every cycle
    always_comb
    begin
        logic [3:0] m;
        logic [3:0] a;
        logic [7:0] m_use;
        logic [7:0] a_use;
        m = 4'h0;
        a = 4'h0;
        m_use = main_elig | ((main_fkind == RCS_FORCE_SLOT) ? (valid_now & (8'h01 << main_fslot))
            : 8'h00);
        a_use = aux_elig | ((aux_fkind == RCS_FORCE_SLOT) ? (valid_now & (8'h01 << aux_fslot))
            : 8'h00);
        m = choose(main_trk_ok_r, main_trk_r, m_use, main_prio_r, m_first_ok, m_first,
            m_first_forced, return_to_best_enable_in, main_fkind);
        a = choose(aux_trk_ok_r, aux_trk_r, a_use, aux_prio_r, a_first_ok, a_first,
            a_first_forced, 1'b1, aux_fkind);
        if (pin_switch_enable_out)
        begin
            // clock switch: validity and revertive bit ignored
            if (switch_select_pin_in)
            begin
                m = {1'b1, (main_prio_r[RCS_SLOT_IN3 * 4 +: 4] != RCS_PRIO_OFF) ? RCS_SLOT_IN3
                    : RCS_SLOT_IN5};
            end
            else
            begin
                m = {1'b1, (main_prio_r[RCS_SLOT_IN4 * 4 +: 4] != RCS_PRIO_OFF) ? RCS_SLOT_IN4
                    : RCS_SLOT_IN6};
            end
        end
        if (aux_measures_main_in)
        begin
            // compared input comes straight from the aux force field
            a = {aux_fkind == RCS_FORCE_SLOT, aux_fslot};
        end
        main_trk_ok_nxt = m[3];
        main_trk_nxt = m[2:0];
        aux_trk_ok_nxt = a[3];
        aux_trk_nxt = a[2:0];
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            main_trk_r <= 3'h0;
            main_trk_ok_r <= 1'b0;
            aux_trk_r <= 3'h0;
            aux_trk_ok_r <= 1'b0;
        end
        else
        begin
            main_trk_r <= main_trk_nxt;
            main_trk_ok_r <= main_trk_ok_nxt;
            aux_trk_r <= aux_trk_nxt;
            aux_trk_ok_r <= aux_trk_ok_nxt;
        end
    end

    // priority tables; the view select steers writes and the read view
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            main_prio_r <= RCS_MAIN_PRIO_RST;
            aux_prio_r <= RCS_AUX_PRIO_RST;
        end
        else if (prio_wr_in)
        begin
            if (priority_view_select_in)
            begin
                aux_prio_r[prio_wr_slot_in * 4 +: 4] <= prio_wr_data_in;
            end
            else
            begin
                main_prio_r[prio_wr_slot_in * 4 +: 4] <= prio_wr_data_in;
            end
        end
    end

    // software view of table and ranking for the selected loop
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            input_priority_regs_out <= 32'h0000_0000;
            ranked_table_view_a_out <= 8'h00;
            ranked_table_view_b_out <= 8'h00;
            main_tracked_out <= RCS_CODE_NONE;
            aux_tracked_out <= RCS_CODE_NONE;
        end
        else
        begin
            main_tracked_out <= code_of(main_trk_ok_nxt, main_trk_nxt);
            aux_tracked_out <= code_of(aux_trk_ok_nxt, aux_trk_nxt);
            if (priority_view_select_in)
            begin
                input_priority_regs_out <= aux_prio_r;
                ranked_table_view_a_out <= {code_of(a_first_ok, a_first),
                    code_of(aux_trk_ok_nxt, aux_trk_nxt)};
                ranked_table_view_b_out <= {code_of(a_third_ok, a_third),
                    code_of(a_second_ok, a_second)};
            end
            else
            begin
                input_priority_regs_out <= main_prio_r;
                ranked_table_view_a_out <= {code_of(m_first_ok, m_first),
                    code_of(main_trk_ok_nxt, main_trk_nxt)};
                ranked_table_view_b_out <= {code_of(m_third_ok, m_third),
                    code_of(m_second_ok, m_second)};
            end
        end
    end

    // fast switching: hold the failed input out until its bucket alarm takes over
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            fast_fail_r <= 8'h00;
            bucket_force_out <= 8'h00;
            enter_prelocked2_out <= 1'b0;
        end
        else
        begin
            fast_fail_r <= (fast_fail_r & ~activity_fault_in)
                | (fast_event ? (8'h01 << main_trk_r) : 8'h00);
            bucket_force_out <= fast_event ? (8'h01 << main_trk_r) : 8'h00;
            enter_prelocked2_out <= fast_event;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            tracked_input_fault_out <= 1'b0;
        end
        else if (missing_cycles_in && main_trk_ok_r)
        begin
            tracked_input_fault_out <= 1'b1;
        end
        else if (tracked_fault_clear_in)
        begin
            tracked_input_fault_out <= 1'b0;
        end
    end

    // strap caught on every reset cycle; the last one before release counts
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            pin_switch_enable_out <= switch_select_pin_in;
            frequency_tolerance_limit_out <= switch_select_pin_in ? RCS_TOL_PIN
                : RCS_TOL_NORMAL;
        end
        else
        begin
            if (pin_switch_wr_in)
            begin
                pin_switch_enable_out <= pin_switch_data_in;
            end
            if (tol_wr_in)
            begin
                frequency_tolerance_limit_out <= tol_data_in;
            end
        end
    end

    // validity status and change latches; a new change beats a clear
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            valid_prev_r <= 8'h00;
            validity_status_a_out <= 8'h00;
            latched_status_a_out <= 8'h00;
            interrupt_request_pin_out <= 1'b0;
        end
        else
        begin
            valid_prev_r <= valid_now;
            validity_status_a_out <= valid_now;
            latched_status_a_out <= (latched_status_a_out & ~latched_clear_in)
                | (valid_now ^ valid_prev_r);
            interrupt_request_pin_out <= |(((latched_status_a_out & ~latched_clear_in)
                | (valid_now ^ valid_prev_r)) & irq_enable_in);
        end
    end

endmodule : rcs_selector

//--- bench/rcs_sel_properties.sv
// checker for rcs_selector: tracking, views, pin and fast switch, status
// assumes the bind below; sees the top ports only
`timescale 1ns/10ps
module rcs_sel_properties
(
    // clock, reset and controls
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic priority_view_select_in,
    input wire logic [3:0] main_loop_force_input_in,
    input wire logic fast_switch_enable_in,
    input wire logic missing_cycles_in,
    input wire logic switch_select_pin_in,
    // results
    input wire logic [7:0] ranked_table_view_a_out,
    input wire logic [3:0] main_tracked_out,
    input wire logic [3:0] aux_tracked_out,
    input wire logic [7:0] validity_status_a_out,
    input wire logic [7:0] latched_status_a_out,
    input wire logic pin_switch_enable_out,
    input wire logic [7:0] bucket_force_out,
    input wire logic enter_prelocked2_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (reset_in);
    sequence s_miss;
        missing_cycles_in && fast_switch_enable_in && main_tracked_out != 4'h0;
    endsequence
    sequence s_bucket;
        enter_prelocked2_out && $onehot(bucket_force_out);
    endsequence
    a_fast_switch_go: assert property (s_miss |=> s_bucket)
        else $error("fast switch missing");
    a_prelock_cause: assert property (enter_prelocked2_out |->
        $past(missing_cycles_in && fast_switch_enable_in))
        else $error("prelocked pulse without cause");
    a_force_none: assert property ((main_loop_force_input_in inside {4'h7, [4'hA:4'hE]}
        && !pin_switch_enable_out)[*2] |-> main_tracked_out == 4'h0)
        else $error("bad force code still tracks");
    a_pin_high_pick: assert property ((pin_switch_enable_out && switch_select_pin_in)[*2]
        |-> main_tracked_out inside {4'h3, 4'h5})
        else $error("pin high wrong input");
    a_pin_low_pick: assert property ((pin_switch_enable_out && !switch_select_pin_in)[*2]
        |-> main_tracked_out inside {4'h4, 4'h6})
        else $error("pin low wrong input");
    a_view_main_trk: assert property ((!priority_view_select_in)[*2]
        |-> ranked_table_view_a_out[3:0] == main_tracked_out)
        else $error("main view tracked mismatch");
    a_view_aux_trk: assert property ((priority_view_select_in)[*2]
        |-> ranked_table_view_a_out[3:0] == aux_tracked_out)
        else $error("aux view tracked mismatch");
    a_latch_on_change: assert property (!$past(reset_in, 2)
        && validity_status_a_out != $past(validity_status_a_out)
        |-> ((validity_status_a_out ^ $past(validity_status_a_out))
        & ~latched_status_a_out) == 8'h00)
        else $error("validity change not latched");
endmodule : rcs_sel_properties

bind rcs_selector rcs_sel_properties u_props (.*);

//--- bench/rcs_far_end.sv
// far-side model: input clock monitors seen as fault levels
// assumes requests change at the falling edge; slow_in adds a cycle
`timescale 1ns/10ps
module rcs_far_end
(
    // clock and mode
    input wire logic clk_in,
    input wire logic slow_in,
    // requested conditions
    input wire logic [7:0] freq_req_in,
    input wire logic [7:0] act_req_in,
    input wire logic [7:0] phase_req_in,
    input wire logic miss_req_in,
    // monitor results
    output logic [7:0] freq_fault_out,
    output logic [7:0] activity_fault_out,
    output logic [7:0] phase_fault_out,
    output logic missing_cycles_out
);
    logic [24:0] stage_r;
    always_ff @(posedge clk_in)
    begin
        stage_r <= {miss_req_in, phase_req_in, act_req_in, freq_req_in};
    end
    // slow monitor reports a cycle late
    assign {missing_cycles_out, phase_fault_out, activity_fault_out, freq_fault_out} =
        slow_in ? stage_r : {miss_req_in, phase_req_in, act_req_in, freq_req_in};
endmodule : rcs_far_end

//--- bench/tb.sv
// self-checking bench for rcs_selector beside the far-end model
// assumes 250 MHz clock; inputs change at the falling edge
`timescale 1ns/10ps
module tb;
    logic clk_in = 1'b0, reset_in = 1'b1, priority_view_select_in = 1'b0, prio_wr_in = 1'b0;
    logic return_to_best_enable_in = 1'b0, aux_measures_main_in = 1'b0, slow = 1'b0;
    logic fast_switch_enable_in = 1'b0, switch_select_pin_in = 1'b0, pin_switch_wr_in = 1'b0;
    logic pin_switch_data_in = 1'b0, tol_wr_in = 1'b0, tracked_fault_clear_in = 1'b0;
    logic miss = 1'b0;
    logic [2:0] prio_wr_slot_in = 3'h0;
    logic [3:0] prio_wr_data_in = 4'h0, main_loop_force_input_in = 4'h0;
    logic [3:0] aux_loop_force_input_in = 4'h0, main_tracked_out, aux_tracked_out;
    logic [9:0] tol_data_in = 10'h000, frequency_tolerance_limit_out;
    logic [7:0] latched_clear_in = 8'h00, irq_enable_in = 8'h00, fq = 8'h00, ac = 8'h00;
    logic [7:0] ph = 8'h00, freq_fault_in, activity_fault_in, phase_fault_in;
    logic [7:0] ranked_table_view_a_out, ranked_table_view_b_out, validity_status_a_out;
    logic [7:0] latched_status_a_out, bucket_force_out;
    logic [31:0] input_priority_regs_out;
    logic missing_cycles_in, interrupt_request_pin_out, tracked_input_fault_out;
    logic pin_switch_enable_out, enter_prelocked2_out;
    int err_count = 0, n_checks = 0, cyc = 0;
    rcs_far_end far (.clk_in, .slow_in(slow), .freq_req_in(fq), .act_req_in(ac),
        .phase_req_in(ph), .miss_req_in(miss), .freq_fault_out(freq_fault_in),
        .activity_fault_out(activity_fault_in), .phase_fault_out(phase_fault_in),
        .missing_cycles_out(missing_cycles_in));
    rcs_selector uut (.clk_in, .reset_in, .priority_view_select_in, .prio_wr_in,
        .prio_wr_slot_in, .prio_wr_data_in, .return_to_best_enable_in,
        .main_loop_force_input_in, .aux_loop_force_input_in, .aux_measures_main_in,
        .fast_switch_enable_in, .freq_fault_in, .activity_fault_in, .phase_fault_in,
        .missing_cycles_in, .switch_select_pin_in, .pin_switch_wr_in, .pin_switch_data_in,
        .tol_wr_in, .tol_data_in, .latched_clear_in, .irq_enable_in, .tracked_fault_clear_in,
        .input_priority_regs_out, .ranked_table_view_a_out, .ranked_table_view_b_out,
        .main_tracked_out, .aux_tracked_out, .validity_status_a_out, .latched_status_a_out,
        .interrupt_request_pin_out, .tracked_input_fault_out, .pin_switch_enable_out,
        .frequency_tolerance_limit_out, .bucket_force_out, .enter_prelocked2_out);
    always #2 clk_in = ~clk_in;
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic step(input int n);
        repeat (n) @(negedge clk_in);
    endtask : step
    // one-cycle strobe, then settling time
    task automatic pulse(ref logic s);
        s = 1'b1;
        step(1);
        s = 1'b0;
        step(4);
    endtask : pulse
    task automatic wr(input logic [2:0] s, input logic [3:0] p);
        prio_wr_slot_in = s;
        prio_wr_data_in = p;
        pulse(prio_wr_in);
    endtask : wr
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : conclude
    always @(posedge clk_in)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_count++;
            conclude();
        end
    end
    initial
    begin
        step(4);
        reset_in = 1'b0;
        step(4);
        chk("prio", input_priority_regs_out, 32'h5400_3210);
        chk("views", {ranked_table_view_a_out, ranked_table_view_b_out}, 16'h2243);
        chk("trk", {main_tracked_out, aux_tracked_out}, 8'h22);
        chk("latch", latched_status_a_out, 8'hFF);
        chk("strap", {pin_switch_enable_out, frequency_tolerance_limit_out}, 11'h05C);
        irq_enable_in = 8'h02;
        step(2);
        chk("irq", interrupt_request_pin_out, 1'b1);
        latched_clear_in = 8'hFF;
        step(2);
        chk("clr", {latched_status_a_out, interrupt_request_pin_out}, 9'h000);
        latched_clear_in = 8'h00;
        priority_view_select_in = 1'b1;
        step(4);
        chk("aux prio", input_priority_regs_out, 32'h0500_3210);
        priority_view_select_in = 1'b0;
        fq = 8'h02;
        ph = 8'h80;
        step(4);
        chk("valid", validity_status_a_out, 8'hFD);
        chk("fail", {main_tracked_out, aux_tracked_out, interrupt_request_pin_out}, 9'h067);
        fq = 8'h00;
        ph = 8'h00;
        step(4);
        chk("nonrev", {ranked_table_view_a_out, main_tracked_out, aux_tracked_out},
            16'h2332);
        pulse(return_to_best_enable_in);
        chk("rev", {main_tracked_out, aux_tracked_out}, 8'h22);
        main_loop_force_input_in = 4'h4;
        step(4);
        chk("forced", {ranked_table_view_a_out, ranked_table_view_b_out}, 16'h4232);
        return_to_best_enable_in = 1'b1;
        for (int c = 0; c < 16; c++)
        begin
            main_loop_force_input_in = 4'(c);
            aux_loop_force_input_in = 4'(c);
            step(4);
            chk("force", {main_tracked_out, aux_tracked_out}, c inside {0, 15} ? 8'h22 :
                c inside {7, [10:14]} ? 8'h00 : {4'(c), 4'(c)});
        end
        main_loop_force_input_in = 4'h0;
        aux_loop_force_input_in = 4'h0;
        wr(3'h1, 4'h0);
        chk("off", {main_tracked_out, aux_tracked_out}, 8'h32);
        wr(3'h1, 4'h1);
        wr(3'h2, 4'h1);
        fq = 8'h02;
        step(4);
        fq = 8'h00;
        step(4);
        chk("equal", {main_tracked_out, aux_tracked_out}, 8'h32);
        wr(3'h2, 4'h2);
        switch_select_pin_in = 1'b1;
        pin_switch_data_in = 1'b1;
        pulse(pin_switch_wr_in);
        chk("pin hi", {ranked_table_view_a_out, main_tracked_out, aux_tracked_out},
            16'h2332);
        switch_select_pin_in = 1'b0;
        fq = 8'h08;
        step(4);
        chk("pin lo", main_tracked_out, 4'h4);
        wr(3'h3, 4'h0);
        chk("pin alt", main_tracked_out, 4'h6);
        wr(3'h3, 4'h3);
        fq = 8'h00;
        pin_switch_data_in = 1'b0;
        pulse(pin_switch_wr_in);
        tol_data_in = 10'h0C8;
        pulse(tol_wr_in);
        chk("tol", frequency_tolerance_limit_out, 10'h0C8);
        aux_measures_main_in = 1'b1;
        aux_loop_force_input_in = 4'h6;
        step(4);
        chk("aux meas", aux_tracked_out, 4'h6);
        aux_measures_main_in = 1'b0;
        aux_loop_force_input_in = 4'h0;
        slow = 1'b1;
        return_to_best_enable_in = 1'b0;
        fast_switch_enable_in = 1'b1;
        pulse(miss);
        chk("fast", {tracked_input_fault_out, validity_status_a_out, main_tracked_out,
            aux_tracked_out}, 17'h1_FD33);
        pulse(tracked_fault_clear_in);
        ac = 8'h02;
        step(4);
        ac = 8'h00;
        step(4);
        chk("recover", {tracked_input_fault_out, validity_status_a_out}, 9'h0FF);
        switch_select_pin_in = 1'b1;
        reset_in = 1'b1;
        step(4);
        reset_in = 1'b0;
        step(2);
        chk("strap", {pin_switch_enable_out, frequency_tolerance_limit_out}, 11'h720);
        conclude();
    end
endmodule : tb
